/* hw/sop_pkg.sv */
// Package: register map, field layout and divider codes for the serial output port
package sop_pkg;

  // Register address and reset value
  localparam logic [15:0] SOP_CTL_ADDR  = 16'h081E;
  localparam logic [15:0] SOP_CTL_RESET = 16'h0000;
  localparam logic [15:0] SOP_CTL_WMASK = 16'h3FFF; // Top two bits read as zero

  // Field positions inside the control word
  localparam int SOP_POS_WPOL  = 13;
  localparam int SOP_POS_BPOL  = 12;
  localparam int SOP_POS_MS    = 11;
  localparam int SOP_POS_BDIV  = 9;
  localparam int SOP_POS_WDIV  = 7;
  localparam int SOP_POS_FSYNC = 6;
  localparam int SOP_POS_TDM   = 5;
  localparam int SOP_POS_MSB   = 2;
  localparam int SOP_POS_WLEN  = 0;

  // Internal clock runs at 1024 times the sample rate
  localparam int SOP_CNT_W = 10;

  // Bit clock divider codes
  localparam logic [1:0] SOP_BDIV_16 = 2'h0;
  localparam logic [1:0] SOP_BDIV_8  = 2'h1;
  localparam logic [1:0] SOP_BDIV_4  = 2'h2;
  localparam logic [1:0] SOP_BDIV_2  = 2'h3;

  // Word clock divider codes
  localparam logic [1:0] SOP_WDIV_1024 = 2'h0;
  localparam logic [1:0] SOP_WDIV_512  = 2'h1;
  localparam logic [1:0] SOP_WDIV_256  = 2'h2;

  // Control word as stored
  typedef struct packed {
    logic [1:0] zero;
    logic       out_word_clock_polarity;
    logic       out_bit_clock_polarity;
    logic       master;
    logic [1:0] out_bit_clock_divider;
    logic [1:0] out_word_clock_divider;
    logic       frame_sync_type;
    logic       tdm;
    logic [2:0] msb_delay;
    logic [1:0] out_word_length;
  } sop_ctl_t;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sop_req_t;

endpackage

/* hw/sop_clkdiv.sv */
// Shared divider that makes master bit clock and word clock from one counter
`timescale 1ns/100ps
module sop_clkdiv #(
  parameter int CNT_W = 10
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       bclk_pol,
  input  wire logic [1:0] bclk_div,
  input  wire logic [1:0] wclk_div,
  output logic            bclk_lvl,
  output logic            wclk_lvl
);
  import sop_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  initial begin
    if (CNT_W != SOP_CNT_W) $error("sop_clkdiv: counter must span 1024 cycles");
  end

  // One counter for both clocks keeps word edges on bit edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Wrap of low bits is a falling edge of the raw bit; inversion makes it the launch edge
  always_comb begin
    case (bclk_div)
      SOP_BDIV_16: bclk_lvl = cnt_r[3] ^ bclk_pol;
      SOP_BDIV_8:  bclk_lvl = cnt_r[2] ^ bclk_pol;
      SOP_BDIV_4:  bclk_lvl = cnt_r[1] ^ bclk_pol;
      default:       bclk_lvl = cnt_r[0] ^ bclk_pol;
    endcase
  end

  // Reserved word code falls back to the slowest rate
  always_comb begin
    case (wclk_div)
      SOP_WDIV_512: wclk_lvl = cnt_r[8];
      SOP_WDIV_256: wclk_lvl = cnt_r[7];
      default:        wclk_lvl = cnt_r[9];
    endcase
  end

endmodule

/* hw/sop_port.sv */
// Serial output port: control register, clock master/slave and data shifter
//
// Functional notes
// - Polarity bit picks which word-clock level carries left.
// - Data launches on bit-clock edge chosen by polarity.
// - Clock pins stay inputs until master bit set.
// - Master bit clock divides internal clock by 16/8/4/2.
// - Master word clock divides internal clock by 1024/512/256.
`timescale 1ns/100ps
module sop_port #(
  parameter int WORD_W = 24
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire sop_pkg::sop_req_t reg_req,
  output logic [15:0]            reg_rdata,
  input  wire logic [WORD_W-1:0] left_word,
  input  wire logic [WORD_W-1:0] right_word,
  output logic                   word_load,
  input  wire logic              bclk_in,
  output logic                   bclk_out,
  output logic                   bclk_oe_n,
  input  wire logic              wclk_in,
  output logic                   wclk_out,
  output logic                   wclk_oe_n,
  output logic                   sdata_out
);
  import sop_pkg::*;

  sop_ctl_t          ctl_r;
  logic              div_bclk;
  logic              div_wclk;
  logic              bclk_r;
  logic              wclk_r;
  logic              bclk_prev_r;
  logic              wclk_seen_r;
  logic              launch;
  logic              left_now;
  logic [WORD_W-1:0] shift_r;
  logic              sdata_r;
  logic              load_r;

  initial begin
    if (WORD_W < 2 || WORD_W > 32) $error("sop_port: WORD_W must be 2 to 32");
  end

  // Control register; writes to other addresses are ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_r <= sop_ctl_t'(SOP_CTL_RESET);
    end else if (reg_req.wr && reg_req.addr == SOP_CTL_ADDR) begin
      ctl_r <= sop_ctl_t'(reg_req.wdata & SOP_CTL_WMASK);
    end
  end

  // Read data held in a flop; unmapped address reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.addr == SOP_CTL_ADDR) begin
      reg_rdata <= ctl_r;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  sop_clkdiv #(
    .CNT_W (SOP_CNT_W)
  ) u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (ctl_r.master),
    .bclk_pol (ctl_r.out_bit_clock_polarity),
    .bclk_div (ctl_r.out_bit_clock_divider),
    .wclk_div (ctl_r.out_word_clock_divider),
    .bclk_lvl (div_bclk),
    .wclk_lvl (div_wclk)
  );

  // Pin drivers; slave keeps pins released so the far end can drive them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bclk_oe_n <= 1'b1;
      wclk_oe_n <= 1'b1;
    end else begin
      bclk_oe_n <= ~ctl_r.master;
      wclk_oe_n <= ~ctl_r.master;
    end
  end

  // Working clock levels: divider in master, sampled pins in slave
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bclk_r <= 1'b0;
      wclk_r <= 1'b0;
    end else if (ctl_r.master) begin
      bclk_r <= div_bclk;
      wclk_r <= div_wclk;
    end else begin
      bclk_r <= bclk_in;
      wclk_r <= wclk_in;
    end
  end

  assign bclk_out = bclk_r;
  assign wclk_out = wclk_r;

  // Edge history for launch detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bclk_prev_r <= 1'b0;
      wclk_seen_r <= 1'b0;
    end else begin
      bclk_prev_r <= bclk_r;
      if (launch) begin
        wclk_seen_r <= wclk_r;
      end
    end
  end

  // Falling edge when polarity is 0, rising when 1
  assign launch   = ctl_r.out_bit_clock_polarity ? (bclk_r & ~bclk_prev_r)
                                                 : (~bclk_r & bclk_prev_r);
  // Left rides the word-clock level equal to the polarity bit
  assign left_now = (wclk_r == ctl_r.out_word_clock_polarity);

  // Shifter: reload at a word edge, else shift MSB first; width beyond word pads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      sdata_r <= 1'b0;
      load_r  <= 1'b0;
    end else begin
      load_r <= 1'b0;
      if (launch && wclk_r != wclk_seen_r) begin
        shift_r <= left_now ? {left_word[WORD_W-2:0], 1'b0}
                            : {right_word[WORD_W-2:0], 1'b0};
        sdata_r <= left_now ? left_word[WORD_W-1] : right_word[WORD_W-1];
        load_r  <= left_now;
      end else if (launch) begin
        shift_r <= {shift_r[WORD_W-2:0], 1'b0};
        sdata_r <= shift_r[WORD_W-1];
      end
    end
  end

  assign sdata_out = sdata_r;
  assign word_load = load_r;

  // Helper: cycles since the last toggle of each clock, valid after a full period
  logic [10:0] bcnt_r;
  logic [10:0] wcnt_r;
  logic [1:0]  bok_r;
  logic [1:0]  wok_r;
  logic [15:0] cfg_prev_r;
  logic        cfg_same;
  logic [10:0] bhalf;
  logic [10:0] whalf;

  assign cfg_same = (cfg_prev_r == 16'(ctl_r)) && ctl_r.master;
  assign bhalf = 11'd8 >> ctl_r.out_bit_clock_divider;
  assign whalf = (ctl_r.out_word_clock_divider == SOP_WDIV_512) ? 11'd256 : 11'd512;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_prev_r <= 16'h0000;
      bcnt_r <= '0;
      wcnt_r <= '0;
      bok_r  <= '0;
      wok_r  <= '0;
    end else begin
      cfg_prev_r <= ctl_r;
      bcnt_r <= ($changed(bclk_r) || !cfg_same) ? 11'd0 : bcnt_r + 11'd1;
      wcnt_r <= ($changed(wclk_r) || !cfg_same) ? 11'd0 : wcnt_r + 11'd1;
      if (!cfg_same) bok_r <= '0;
      else if ($changed(bclk_r) && bok_r != 2'd2) bok_r <= bok_r + 2'd1;
      if (!cfg_same) wok_r <= '0;
      else if ($changed(wclk_r) && wok_r != 2'd2) wok_r <= wok_r + 2'd1;
    end
  end

  sequence s_word_edge;
    $changed(wclk_r);
  endsequence

  sequence s_new_word_out;
    ##1 (sdata_r == ($past(left_now) ? $past(left_word[WORD_W-1])
                                     : $past(right_word[WORD_W-1])));
  endsequence

  AST_SLAVE_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
    !$past(ctl_r.master) |-> (bclk_oe_n && wclk_oe_n))
    else $error("clock pins driven while slave");

  AST_MASTER_DRIVE: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ctl_r.master) |=> (!bclk_oe_n && !wclk_oe_n))
    else $error("master did not drive clock pins");

  AST_DATA_ON_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    $changed(sdata_r) |-> $past(launch) && $past(ctl_r.out_bit_clock_polarity ?
      (bclk_r && !bclk_prev_r) : (!bclk_r && bclk_prev_r)))
    else $error("data changed away from launch edge");

  AST_LEFT_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
    load_r |-> ($past(wclk_r) == $past(ctl_r.out_word_clock_polarity)))
    else $error("left word loaded on wrong word-clock level");

  AST_BCLK_HALF: assert property (@(posedge core_clk) disable iff (rst)
    (cfg_same && bok_r == 2'd2 && $changed(bclk_r)) |->
      (bcnt_r + 11'd1 == bhalf))
    else $error("bit clock half period wrong");

  AST_WCLK_HALF: assert property (@(posedge core_clk) disable iff (rst)
    (cfg_same && wok_r == 2'd2 && $changed(wclk_r)
      && ctl_r.out_word_clock_divider != SOP_WDIV_256) |->
      (wcnt_r + 11'd1 == whalf))
    else $error("word clock half period wrong");

  AST_WORD_ON_BIT_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    (ctl_r.master && $past(ctl_r.master) && $past(cfg_same)) and s_word_edge |-> launch)
    else $error("word edge not aligned to launch edge");

  AST_WORD_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
    (launch && wclk_r != wclk_seen_r) |-> s_new_word_out)
    else $error("word edge did not reload channel MSB");

endmodule

/* tb/sop_rx_model.sv */
// Far-side receiver model, also the clock source while the port is a slave
`timescale 1ns/100ps
module sop_rx_model (
  input  wire logic        core_clk,
  input  wire logic        drive,
  input  wire logic        bclk_pol,
  input  wire logic        wclk_pol,
  input  wire logic        bclk,
  input  wire logic        wclk,
  input  wire logic        sdata,
  output logic             bclk_gen,
  output logic             wclk_gen,
  output logic [23:0]      left_rx,
  output logic [23:0]      right_rx
);
  logic [9:0]  cnt_r = 10'h000;
  logic        bclk_d = 1'b0;
  logic        wclk_d = 1'b0;
  logic        nw = 1'b0;
  logic [23:0] sh = 24'h00_0000;
  int          idx = 99;

  // Clocks advance only while driving; word edge sits on a bit clock rise
  always @(posedge core_clk) begin
    if (drive) cnt_r <= cnt_r + 10'h001;
  end
  assign bclk_gen = ~cnt_r[3];
  assign wclk_gen = cnt_r[9];

  // Word edges are seen at launch, bits taken on the other edge
  always @(posedge core_clk) begin
    bclk_d <= bclk;
    if (bclk !== bclk_d && bclk === bclk_pol) begin
      nw <= (wclk !== wclk_d);
      wclk_d <= wclk;
    end
    if (bclk !== bclk_d && bclk === ~bclk_pol) begin
      idx = nw ? 0 : (idx < 99 ? idx + 1 : 99);
      if (idx < 24) sh[23 - idx] = sdata;
      if (idx == 23 && wclk_d === wclk_pol) left_rx <= sh;
      if (idx == 23 && wclk_d !== wclk_pol) right_rx <= sh;
    end
  end
endmodule

/* tb/test_serial_output_port_clock_control.sv */
// Testbench: register access, master dividers, framing and slave mode
`timescale 1ns/100ps
module test_serial_output_port_clock_control;
  import sop_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  sop_req_t    reg_req = '0;
  logic [15:0] reg_rdata;
  logic [23:0] left_word = 24'h00_0000;
  logic [23:0] right_word = 24'h00_0000;
  logic [23:0] left_rx, right_rx;
  logic        word_load, bclk_in, bclk_out, bclk_oe_n, wclk_in, wclk_out, wclk_oe_n;
  logic        sdata_out, bclk_gen, wclk_gen;
  logic        drive = 1'b0, bpol = 1'b0, pol = 1'b0;
  int          err_total = 0;
  int          tests_run = 0;

  always #50 core_clk = ~core_clk;
  // Pin level: far side drives the clocks only while the port is a slave
  assign bclk_in = bclk_oe_n ? bclk_gen : bclk_out;
  assign wclk_in = wclk_oe_n ? wclk_gen : wclk_out;

  sop_port DUT (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .left_word(left_word), .right_word(right_word), .word_load(word_load),
    .bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .wclk_in(wclk_in),
    .wclk_out(wclk_out), .wclk_oe_n(wclk_oe_n), .sdata_out(sdata_out));
  sop_rx_model RX (.core_clk(core_clk), .drive(drive), .bclk_pol(bpol), .wclk_pol(pol),
    .bclk(bclk_in), .wclk(wclk_in), .sdata(sdata_out), .bclk_gen(bclk_gen),
    .wclk_gen(wclk_gen), .left_rx(left_rx), .right_rx(right_rx));

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  // Read data lands one cycle after the address
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    @(posedge core_clk);
    #1 d = reg_rdata;
  endtask

  // Period between 2nd and 3rd rise, skipping any glitch from a code change
  task automatic per(input bit w, input logic [23:0] exp, input string msg);
    logic p, pb, pw;
    int   n, k, i;
    n = 0;
    k = 0;
    for (i = 0; i < 4000 && k < 3; i++) begin
      p = w ? wclk_out : bclk_out;
      pb = bclk_out;
      pw = wclk_out;
      @(posedge core_clk);
      #1;
      if (k > 1) n++;
      if ((w ? wclk_out : bclk_out) && !p) k++;
      if (k > 1 && wclk_out !== pw)
        check({23'h0, bclk_out !== pb && bclk_out === bpol}, 24'h1, "align");
    end
    check(24'(n), exp, msg);
  endtask

  task automatic t_regs;
    logic [15:0] d;
    rd(SOP_CTL_ADDR, d);
    check({8'h00, d}, {8'h00, SOP_CTL_RESET}, "reset value");
    check({22'h0, bclk_oe_n, wclk_oe_n}, 24'h3, "slave at reset");
    wr(SOP_CTL_ADDR, 16'hF7FF);
    rd(SOP_CTL_ADDR, d);
    check({8'h00, d}, 24'h00_37FF, "write mask");
    wr(16'h081F, 16'h0000);
    rd(SOP_CTL_ADDR, d);
    check({8'h00, d}, 24'h00_37FF, "unmapped write");
    rd(16'h081F, d);
    check({8'h00, d}, 24'h00_0000, "unmapped read");
    check({22'h0, bclk_oe_n, wclk_oe_n}, 24'h3, "slave without master bit");
    $display("test regs done");
  endtask

  task automatic t_div;
    int c;
    bpol = 1'b0;
    for (c = 0; c < 4; c++) begin
      wr(SOP_CTL_ADDR, 16'h0800 | 16'(c << 9));
      per(1'b0, 24'(16 >> c), "bit clock period");
    end
    check({22'h0, bclk_oe_n, wclk_oe_n}, 24'h0, "master drives");
    for (c = 0; c < 2; c++) begin
      bpol = c[0];
      wr(SOP_CTL_ADDR, 16'h0800 | 16'(c << 12) | 16'(c << 7));
      per(1'b1, 24'(1024 >> c), "word clock period");
    end
    $display("test dividers done");
  endtask

  // All four polarity pairs, fresh words each time so stale captures fail
  task automatic t_data;
    int c;
    int i;
    for (c = 0; c < 4; c++) begin
      pol = c[1];
      bpol = c[0];
      @(posedge core_clk);
      left_word <= 24'hC3_5A00 + 24'(c);
      right_word <= 24'h3C_A5F0 + 24'(c);
      wr(SOP_CTL_ADDR, 16'h0800 | 16'(c << 12));
      repeat (3072) @(posedge core_clk);
      check(left_rx, 24'hC3_5A00 + 24'(c), "left word");
      check(right_rx, 24'h3C_A5F0 + 24'(c), "right word");
      // A left load pulse must appear once per frame
      i = 0;
      while (i < 1100 && word_load !== 1'b1) begin
        @(posedge core_clk);
        #1;
        i++;
      end
      check({23'h0, word_load}, 24'h1, "left word load");
    end
    $display("test data done");
  endtask

  task automatic t_slave;
    pol = 1'b0;
    bpol = 1'b0;
    // Fresh words so captures left over from master mode cannot pass
    left_word <= 24'h12_3456;
    right_word <= 24'h65_4321;
    wr(SOP_CTL_ADDR, 16'h0000);
    drive <= 1'b1;
    repeat (3072) @(posedge core_clk);
    check({22'h0, bclk_oe_n, wclk_oe_n}, 24'h3, "slave pins released");
    check(left_rx, 24'h12_3456, "slave left word");
    check(right_rx, 24'h65_4321, "slave right word");
    drive <= 1'b0;
    $display("test slave done");
  endtask

  task automatic tally_and_finish;
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well past the roughly 20000 cycles the tests need
  initial begin
    #(100 * 40000);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_div;
    t_data;
    t_slave;
    tally_and_finish;
  end
endmodule
